// ---- logic/urm_pkg.sv ----
// Shared constants and carrier types for the UART register map slice.
package urm_pkg;
    // Register offsets in the normal map.
    localparam logic [3:0] OFS_HOLD = 4'h0;
    localparam logic [3:0] OFS_IRQMASK = 4'h1;
    localparam logic [3:0] OFS_CAUSE = 4'h2;
    localparam logic [3:0] OFS_FORMAT = 4'h3;
    localparam logic [3:0] OFS_LINESTAT = 4'h5;
    localparam logic [3:0] OFS_PINSTATE = 4'hb;
    localparam logic [3:0] OFS_PINMASK = 4'hc;
    localparam logic [3:0] OFS_RESERVED = 4'hd;
    localparam logic [3:0] OFS_PINCTRL = 4'he;
    localparam logic [3:0] OFS_EXTRA = 4'hf;
    // Offsets of the divisor and enhanced banks.
    localparam logic [3:0] OFS_DIVLO = 4'h0;
    localparam logic [3:0] OFS_DIVHI = 4'h1;
    localparam logic [3:0] OFS_DIVFRAC = 4'h2;
    localparam logic [3:0] OFS_ENHANCED = 4'h2;
    localparam logic [3:0] OFS_RESUME1 = 4'h4;
    localparam logic [3:0] OFS_RESUME2 = 4'h5;
    localparam logic [3:0] OFS_PAUSE1 = 4'h6;
    localparam logic [3:0] OFS_PAUSE2 = 4'h7;
    // Line format value that opens the enhanced bank.
    localparam logic [7:0] FORMAT_ENH_KEY = 8'hbf;
    // Field positions.
    localparam int FORMAT_DIV_BIT = 7;
    localparam int ENH_UNLOCK_BIT = 4;
    localparam int SETUP_FIFO_EN_BIT = 0;
    localparam int SETUP_RX_RST_BIT = 1;
    localparam int SETUP_TX_RST_BIT = 2;
    localparam int MASK_RX_BIT = 0;
    localparam int MASK_TX_BIT = 1;
    localparam int MASK_LINE_BIT = 2;
    localparam int MASK_MODEM_BIT = 3;
    // Masks of bits that only change while the enhanced bank is unlocked.
    localparam logic [7:0] MASK_SHADED = 8'hf0;
    localparam logic [7:0] SETUP_SHADED = 8'h30;
    // Reset values.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RESET_DIVLO = 8'h01;
    // Receive storage.
    localparam int FIFO_DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;
    // Receive trigger levels chosen by setup bits 7:6.
    localparam logic [6:0] TRIG_L0 = 7'h08;
    localparam logic [6:0] TRIG_L1 = 7'h10;
    localparam logic [6:0] TRIG_L2 = 7'h38;
    localparam logic [6:0] TRIG_L3 = 7'h3c;
    // Cause codes in bits 5:0, highest priority first.
    localparam logic [5:0] CAUSE_LINE = 6'h06;
    localparam logic [5:0] CAUSE_RXDATA = 6'h04;
    localparam logic [5:0] CAUSE_TXRDY = 6'h02;
    localparam logic [5:0] CAUSE_MODEM = 6'h00;
    localparam logic [5:0] CAUSE_NONE = 6'h01;

    // Pending interrupt sources before masking.
    typedef struct packed {
        logic line;
        logic rxData;
        logic txRdy;
        logic modem;
    } urm_irq_src_type;

    // Baud generator settings handed to the rate logic.
    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic [7:0] fraction;
    } urm_divisor_type;

    // Flow-control characters.
    typedef struct packed {
        logic [7:0] resume1;
        logic [7:0] resume2;
        logic [7:0] pause1;
        logic [7:0] pause2;
    } urm_flow_chars_type;
endpackage : urm_pkg

// ---- logic/urm_rx_mem.sv ----
// Receive character storage with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module urm_rx_mem
    import urm_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Write side.
    input wire logic wrEn,
    input wire logic [PTR_W-1:0] wrAddr,
    input wire logic [7:0] wrData,
    // Read side; data shows the slot named by rdAddr one edge later.
    input wire logic [PTR_W-1:0] rdAddr,
    output logic [7:0] rdData
);
    // All storage of this module.
    typedef struct packed {
        logic [FIFO_DEPTH-1:0][7:0] mem;
        logic [7:0] rdData;
    } urm_mem_state_type;

    urm_mem_state_type state_reg;
    urm_mem_state_type state_next;

    // Write a slot and fetch the slot to read, passing a same-edge write straight through.
    always_comb begin
        state_next = state_reg;
        if (wrEn) begin
            state_next.mem[wrAddr] = wrData;
        end
        state_next.rdData = state_next.mem[rdAddr];
    end

    // Register the whole state.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdData = state_reg.rdData;
endmodule : urm_rx_mem
`default_nettype wire

// ---- logic/urm_irq_prio.sv ----
// Masks interrupt sources and encodes the highest pending one.
`timescale 1ns/1ns
`default_nettype none
module urm_irq_prio
    import urm_pkg::*;
(
    // Sources and the mask bits that gate them.
    input wire urm_irq_src_type src,
    input wire logic [3:0] mask,
    // Encoded cause and the combined request.
    output logic [5:0] cause,
    output logic pending
);
    // Gate each source with its mask bit.
    urm_irq_src_type gated;

    always_comb begin
        gated.line = src.line & mask[MASK_LINE_BIT];
        gated.rxData = src.rxData & mask[MASK_RX_BIT];
        gated.txRdy = src.txRdy & mask[MASK_TX_BIT];
        gated.modem = src.modem & mask[MASK_MODEM_BIT];
    end

    // Highest priority wins; lower ones wait until it is serviced.
    always_comb begin
        if (gated.line) begin
            cause = CAUSE_LINE;
        end else if (gated.rxData) begin
            cause = CAUSE_RXDATA;
        end else if (gated.txRdy) begin
            cause = CAUSE_TXRDY;
        end else if (gated.modem) begin
            cause = CAUSE_MODEM;
        end else begin
            cause = CAUSE_NONE;
        end
        pending = |gated;
    end
endmodule : urm_irq_prio
`default_nettype wire

// ---- logic/urm_regs.sv ----
// Register map of the serial-attached UART with receive buffer and interrupt cause.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// [R1] Mask register gates the four interrupt sources.
// [R2] Enabled interrupts are reported in cause register.
// [R3] FIFO mode raises receive interrupt at trigger.
// [R4] Trigger reached shows in cause bits 2,3; the code sets only bit 2 (cause code 04).
// [R5] Below trigger clears interrupt and cause together.
// [R6] Data ready sets when character enters buffer.
// [R7] Data ready clears when buffer becomes empty.
// [R8] Shaded bits change only while unlock bit set.
// [R9] Receive holding register is read-only, oldest first.
// [R10] Transmit holding register is write-only, sends character.
// [R11] Cause read returns highest pending, others queued.
// [R12] Cause bit 0 reads one when idle.
// [R13] Line format selects divisor and enhanced banks.
// [R14] Reserved offset reads zero, ignores writes.
module urm_regs
    import urm_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Register port from the serial slave interface.
    input wire logic [3:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regRdValid,
    // Receiver side: characters leaving the receive shift register.
    input wire logic rxCharValid,
    input wire logic [7:0] rxChar,
    // Transmitter side.
    output logic txCharValid,
    output logic [7:0] txChar,
    output logic txFifoReset,
    input wire logic txHoldEmpty,
    input wire logic txAllEmpty,
    // Modem status change from the modem block.
    input wire logic modemChange,
    // Settings for the surrounding logic.
    output urm_divisor_type divisor,
    output urm_flow_chars_type flowChars,
    output logic [7:0] enhancedCtrl,
    output logic [7:0] lineFormat,
    output logic [7:0] extraCtrl,
    output logic [7:0] pinState,
    output logic [7:0] pinMask,
    output logic [7:0] pinCtrl,
    // Interrupt pin toward the host.
    output logic irqN
);
    // All state of the block.
    typedef struct packed {
        logic [7:0] divLo;
        logic [7:0] divHi;
        logic [7:0] divFrac;
        logic [7:0] enh;
        logic [7:0] resume1;
        logic [7:0] resume2;
        logic [7:0] pause1;
        logic [7:0] pause2;
        logic [7:0] pinState;
        logic [7:0] pinMask;
        logic [7:0] pinCtrl;
        logic [7:0] extra;
        logic [7:0] format;
        logic [7:0] irqMask;
        logic [7:0] setup;
        logic overrun;
        logic txPend;
        logic txEmptyLast;
        logic [PTR_W-1:0] wrPtr;
        logic [PTR_W-1:0] rdPtr;
        logic [CNT_W-1:0] count;
        logic [7:0] rdata;
        logic rdValid;
        logic txValid;
        logic [7:0] txChar;
        logic txRst;
        logic irqN;
    } urm_state_type;

    urm_state_type state_reg;
    urm_state_type state_next;

    // Merge a write into a register, keeping shaded bits unless unlocked.
    function automatic logic [7:0] shadedWrite(input logic [7:0] old, input logic [7:0] wr,
                                               input logic [7:0] shaded, input logic unlock);
        shadedWrite = unlock ? wr : ((wr & ~shaded) | (old & shaded));
    endfunction : shadedWrite

    // Trigger level picked by setup bits 7:6.
    function automatic logic [CNT_W-1:0] trigLevel(input logic [1:0] sel);
        case (sel)
            2'h0: trigLevel = TRIG_L0;
            2'h1: trigLevel = TRIG_L1;
            2'h2: trigLevel = TRIG_L2;
            default: trigLevel = TRIG_L3;
        endcase
    endfunction : trigLevel

    // Decode helpers for the three register banks, the receive buffer and interrupts.
    logic bankEnh;
    logic bankDiv;
    logic unlock;
    logic fifoOn;
    logic [CNT_W-1:0] capacity;
    logic full;
    logic empty;
    logic pushReq;
    logic popReq;
    logic [7:0] memRdata;
    logic [7:0] lineStatus;
    logic [5:0] cause;
    logic irqPending;
    urm_irq_src_type src;

    assign bankEnh = (state_reg.format == FORMAT_ENH_KEY); // [R13]
    assign bankDiv = state_reg.format[FORMAT_DIV_BIT] && !bankEnh; // [R13]
    assign unlock = state_reg.enh[ENH_UNLOCK_BIT];
    assign fifoOn = state_reg.setup[SETUP_FIFO_EN_BIT];
    // Without the FIFO the receive path holds one character.
    assign capacity = fifoOn ? CNT_W'(FIFO_DEPTH) : CNT_W'(1);
    assign full = (state_reg.count >= capacity);
    assign empty = (state_reg.count == '0);
    assign pushReq = rxCharValid && !full;
    // Reading the receive holding register takes the oldest character.
    assign popReq = regRd && !bankEnh && !bankDiv && (regAddr == OFS_HOLD) && !empty; // [R9]

    // Line status: data ready follows buffer occupancy.
    always_comb begin
        lineStatus = RESET_BYTE;
        lineStatus[0] = !empty; // [R6] [R7]
        lineStatus[1] = state_reg.overrun;
        lineStatus[5] = txHoldEmpty;
        lineStatus[6] = txAllEmpty;
    end

    // Interrupt sources before masking.
    always_comb begin
        src.line = state_reg.overrun;
        // FIFO mode compares against the trigger; otherwise any held character.
        src.rxData = fifoOn ? (state_reg.count >= trigLevel(state_reg.setup[7:6])) : !empty; // [R3] [R5]
        src.txRdy = state_reg.txPend;
        src.modem = modemChange;
    end

    // Mask and priority encoding.
    urm_irq_prio uPrio (
        .src(src),
        .mask(state_reg.irqMask[3:0]),
        .cause(cause),
        .pending(irqPending)
    );

    // Receive character storage.
    urm_rx_mem uMem (
        .mclk(mclk),
        .rstn(rstn),
        .wrEn(pushReq),
        .wrAddr(state_reg.wrPtr),
        .wrData(rxChar),
        .rdAddr(state_next.rdPtr),
        .rdData(memRdata)
    );

    // Next-state logic for registers, buffer pointers and read data.
    always_comb begin
        state_next = state_reg;
        state_next.rdValid = regRd;
        state_next.txValid = 1'b0;
        state_next.txRst = 1'b0;
        state_next.rdata = RESET_BYTE;
        state_next.irqN = !irqPending; // [R3] [R5]
        state_next.txEmptyLast = txHoldEmpty;
        // Buffer bookkeeping.
        if (pushReq) begin
            state_next.wrPtr = state_reg.wrPtr + PTR_W'(1);
        end
        if (popReq) begin
            state_next.rdPtr = state_reg.rdPtr + PTR_W'(1);
        end
        state_next.count = state_reg.count + CNT_W'(pushReq) - CNT_W'(popReq);
        // Register reads.
        if (regRd) begin
            if (bankEnh) begin
                case (regAddr)
                    OFS_DIVLO: state_next.rdata = state_reg.divLo;
                    OFS_DIVHI: state_next.rdata = state_reg.divHi;
                    OFS_ENHANCED: state_next.rdata = state_reg.enh; // [R13]
                    OFS_FORMAT: state_next.rdata = state_reg.format;
                    OFS_RESUME1: state_next.rdata = state_reg.resume1;
                    OFS_RESUME2: state_next.rdata = state_reg.resume2;
                    OFS_PAUSE1: state_next.rdata = state_reg.pause1;
                    OFS_PAUSE2: state_next.rdata = state_reg.pause2;
                    default: state_next.rdata = RESET_BYTE;
                endcase
            end else if (bankDiv && regAddr <= OFS_DIVFRAC) begin
                case (regAddr)
                    OFS_DIVLO: state_next.rdata = state_reg.divLo; // [R13]
                    OFS_DIVHI: state_next.rdata = state_reg.divHi;
                    default: state_next.rdata = state_reg.divFrac;
                endcase
            end else begin
                case (regAddr)
                    OFS_HOLD: state_next.rdata = empty ? RESET_BYTE : memRdata; // [R9]
                    OFS_IRQMASK: state_next.rdata = state_reg.irqMask;
                    OFS_CAUSE: begin
                        // Highest pending source; bit 0 high when idle.
                        state_next.rdata = {{2{fifoOn}}, cause}; // [R2] [R4] [R11] [R12]
                        if (cause == CAUSE_TXRDY) begin
                            state_next.txPend = 1'b0;
                        end
                    end
                    OFS_FORMAT: state_next.rdata = state_reg.format;
                    OFS_LINESTAT: begin
                        state_next.rdata = lineStatus;
                        state_next.overrun = 1'b0;
                    end
                    OFS_PINSTATE: state_next.rdata = state_reg.pinState;
                    OFS_PINMASK: state_next.rdata = state_reg.pinMask;
                    OFS_RESERVED: state_next.rdata = RESET_BYTE; // [R14]
                    OFS_PINCTRL: state_next.rdata = state_reg.pinCtrl;
                    OFS_EXTRA: state_next.rdata = state_reg.extra;
                    default: state_next.rdata = RESET_BYTE;
                endcase
            end
        end
        // Register writes.
        if (regWr) begin
            if (regAddr == OFS_FORMAT) begin
                state_next.format = regWdata;
            end else if (bankEnh) begin
                case (regAddr)
                    OFS_DIVLO: state_next.divLo = regWdata;
                    OFS_DIVHI: state_next.divHi = regWdata;
                    OFS_ENHANCED: state_next.enh = regWdata; // [R13]
                    OFS_RESUME1: state_next.resume1 = regWdata;
                    OFS_RESUME2: state_next.resume2 = regWdata;
                    OFS_PAUSE1: state_next.pause1 = regWdata;
                    OFS_PAUSE2: state_next.pause2 = regWdata;
                    default: state_next.format = state_reg.format;
                endcase
            end else if (bankDiv && regAddr <= OFS_DIVFRAC) begin
                case (regAddr)
                    OFS_DIVLO: state_next.divLo = regWdata; // [R13]
                    OFS_DIVHI: state_next.divHi = regWdata;
                    default: begin
                        // Fractional divisor and sampling mode are fully shaded.
                        if (unlock) begin
                            state_next.divFrac = regWdata; // [R8]
                        end
                    end
                endcase
            end else begin
                case (regAddr)
                    OFS_HOLD: begin
                        // Hand a character to the transmitter.
                        state_next.txValid = 1'b1; // [R10]
                        state_next.txChar = regWdata;
                        state_next.txPend = 1'b0;
                    end
                    OFS_IRQMASK: begin
                        state_next.irqMask = shadedWrite(state_reg.irqMask, regWdata,
                                                         MASK_SHADED, unlock); // [R8] [R1]
                        // Enabling transmit ready while empty raises it at once.
                        if (regWdata[MASK_TX_BIT] && !state_reg.irqMask[MASK_TX_BIT]
                            && txHoldEmpty) begin
                            state_next.txPend = 1'b1;
                        end
                    end
                    OFS_CAUSE: begin
                        state_next.setup = shadedWrite(state_reg.setup, regWdata,
                                                       SETUP_SHADED, unlock); // [R8]
                        state_next.setup[SETUP_RX_RST_BIT] = 1'b0;
                        state_next.setup[SETUP_TX_RST_BIT] = 1'b0;
                        state_next.txRst = regWdata[SETUP_TX_RST_BIT];
                        // Flushing the receive buffer drops a same-edge arrival too.
                        if (regWdata[SETUP_RX_RST_BIT]) begin
                            state_next.wrPtr = '0;
                            state_next.rdPtr = '0;
                            state_next.count = '0;
                        end
                    end
                    OFS_PINSTATE: state_next.pinState = regWdata;
                    OFS_PINMASK: state_next.pinMask = regWdata;
                    OFS_PINCTRL: state_next.pinCtrl = regWdata;
                    OFS_EXTRA: state_next.extra = regWdata;
                    default: state_next.format = state_reg.format; // [R14]
                endcase
            end
        end
        // Transmit ready raises on hold register emptying; this beats the clears above.
        if (txHoldEmpty && !state_reg.txEmptyLast) begin
            state_next.txPend = 1'b1;
        end
        // A character arriving to a full buffer is lost; this beats the read clear.
        if (rxCharValid && full) begin
            state_next.overrun = 1'b1;
        end
    end

    // Register the whole state.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
            state_reg.divLo <= RESET_DIVLO;
            state_reg.irqN <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from state.
    assign regRdata = state_reg.rdata;
    assign regRdValid = state_reg.rdValid;
    assign txCharValid = state_reg.txValid;
    assign txChar = state_reg.txChar;
    assign txFifoReset = state_reg.txRst;
    assign divisor = '{low: state_reg.divLo, high: state_reg.divHi, fraction: state_reg.divFrac};
    assign flowChars = '{resume1: state_reg.resume1, resume2: state_reg.resume2,
                         pause1: state_reg.pause1, pause2: state_reg.pause2};
    assign enhancedCtrl = state_reg.enh;
    assign lineFormat = state_reg.format;
    assign extraCtrl = state_reg.extra;
    assign pinState = state_reg.pinState;
    assign pinMask = state_reg.pinMask;
    assign pinCtrl = state_reg.pinCtrl;
    assign irqN = state_reg.irqN;
endmodule : urm_regs
`default_nettype wire

// ---- tb/urm_host_model.sv ----
// Host-side model of the register port and receiver.
`timescale 1ns/1ns
`default_nettype none
module urm_host_model
(
    // Clock.
    input wire logic mclk,
    // Register port toward the device.
    output var logic [3:0] regAddr,
    output var logic regWr,
    output var logic regRd,
    output var logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // Characters arriving from the receive shift register.
    output var logic rxCharValid,
    output var logic [7:0] rxChar
);
    // Idle values at time zero.
    initial begin
        regAddr = 4'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        regWdata = 8'h00;
        rxCharValid = 1'b0;
        rxChar = 8'h00;
    end

    // One write, then a spare edge.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        regAddr = a;
        regWdata = v;
        regWr = 1'b1;
        @(posedge mclk);
        #1 regWr = 1'b0;
        @(posedge mclk);
        #1;
    endtask : wr

    // One read; data stands one cycle.
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        regAddr = a;
        regRd = 1'b1;
        @(posedge mclk);
        #1 regRd = 1'b0;
        v = regRdata;
        @(posedge mclk);
        #1;
    endtask : rd

    // One received character.
    task automatic push(input logic [7:0] c);
        rxChar = c;
        rxCharValid = 1'b1;
        @(posedge mclk);
        #1 rxCharValid = 1'b0;
        @(posedge mclk);
        #1;
    endtask : push
endmodule : urm_host_model
`default_nettype wire

// ---- tb/urm_regs_properties.sv ----
// Concurrent checks on the register map ports.
`timescale 1ns/1ns
`default_nettype none
module urm_regs_properties
    import urm_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Watched ports.
    input wire logic [3:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regRdValid,
    input wire logic txCharValid,
    input wire logic [7:0] txChar,
    input wire logic txFifoReset,
    input wire urm_divisor_type divisor,
    input wire logic [7:0] enhancedCtrl,
    input wire logic [7:0] lineFormat,
    input wire logic irqN
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Read answer timing.
    AST_RD_ANSWER: assert property (regRdValid == $past(regRd))
        else $error("read timing");
    AST_RD_IDLE: assert property (!regRdValid |-> regRdata == 8'h00)
        else $error("idle data");
    // Reserved slot.
    AST_RSVD_ZERO: assert property (regRd && regAddr == OFS_RESERVED |=> regRdata == 8'h00)
        else $error("reserved read");
    // Register writes.
    AST_TX_WRITE: assert property (regWr && regAddr == OFS_HOLD && !lineFormat[7]
        |=> txCharValid && txChar == $past(regWdata))
        else $error("hold write");
    AST_TX_CAUSE: assert property (txCharValid |-> $past(regWr) && $past(regAddr) == OFS_HOLD)
        else $error("stray tx pulse");
    AST_FORMAT_WR: assert property (regWr && regAddr == OFS_FORMAT |=> lineFormat == $past(regWdata))
        else $error("format write");
    AST_DIVLO_WR: assert property (regWr && regAddr == OFS_DIVLO && lineFormat[7]
        |=> divisor.low == $past(regWdata))
        else $error("divlo write");
    AST_ENH_WR: assert property (regWr && regAddr == OFS_ENHANCED && lineFormat == FORMAT_ENH_KEY
        |=> enhancedCtrl == $past(regWdata))
        else $error("enh write");
    AST_FRAC_LOCK: assert property (regWr && regAddr == OFS_DIVFRAC && lineFormat[7]
        && lineFormat != FORMAT_ENH_KEY && !enhancedCtrl[4] |=> $stable(divisor.fraction))
        else $error("frac lock");
    AST_TXRST: assert property (regWr && regAddr == OFS_CAUSE && !lineFormat[7] && regWdata[2]
        |=> txFifoReset ##1 !txFifoReset)
        else $error("tx flush");

    // Main scenarios reached.
    COV_READ: cover property (regRd ##1 regRdValid);
    COV_IRQ: cover property ($fell(irqN));
    COV_ENH: cover property (regWr && lineFormat == FORMAT_ENH_KEY);
endmodule : urm_regs_properties

bind urm_regs urm_regs_properties i_urm_regs_properties (.mclk(mclk), .rstn(rstn),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata),
    .regRdata(regRdata), .regRdValid(regRdValid), .txCharValid(txCharValid),
    .txChar(txChar), .txFifoReset(txFifoReset), .divisor(divisor),
    .enhancedCtrl(enhancedCtrl), .lineFormat(lineFormat), .irqN(irqN));
`default_nettype wire

// ---- tb/urm_regs_tb.sv ----
// Self-checking bench for the register map.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errTotal++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module urm_regs_tb;
    import urm_pkg::*;
    logic mclk, rstn, txHoldEmpty, txAllEmpty, modemChange;
    logic [3:0] regAddr;
    logic regWr, regRd, rxCharValid, regRdValid, txCharValid, txFifoReset, irqN;
    logic [7:0] regWdata, regRdata, rxChar, txChar, d;
    urm_divisor_type divisor;
    urm_flow_chars_type flowChars;
    int errTotal = 0;
    int checks = 0;

    urm_regs i_urm_regs (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
        .rxCharValid(rxCharValid), .rxChar(rxChar), .txCharValid(txCharValid),
        .txChar(txChar), .txFifoReset(txFifoReset), .txHoldEmpty(txHoldEmpty),
        .txAllEmpty(txAllEmpty), .modemChange(modemChange), .divisor(divisor),
        .flowChars(flowChars), .enhancedCtrl(), .lineFormat(), .extraCtrl(),
        .pinState(), .pinMask(), .pinCtrl(), .irqN(irqN));
    urm_host_model i_urm_host_model (.mclk(mclk), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
        .rxCharValid(rxCharValid), .rxChar(rxChar));

    // One write through the host model.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        i_urm_host_model.wr(a, v);
    endtask : wr

    // Read and compare.
    task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
        i_urm_host_model.rd(a, d);
        `CHK("regRdata", e, d)
    endtask : rdChk

    // Verdict.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // Free-running 100 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Watchdog.
    initial begin
        #100000;
        errTotal++;
        print_verdict();
    end

    // Test sequence.
    initial begin
        rstn = 1'b0;
        txHoldEmpty = 1'b0;
        txAllEmpty = 1'b0;
        modemChange = 1'b0;
        repeat (20) @(posedge mclk);
        #1 rstn = 1'b1;
        `CHK("irqN", 1'b1, irqN)
        rdChk(OFS_CAUSE, 8'h01);
        rdChk(OFS_IRQMASK, 8'h00);
        rdChk(OFS_LINESTAT, 8'h00);
        `CHK("divLow", RESET_DIVLO, divisor.low)
        wr(OFS_RESERVED, 8'hff);
        rdChk(OFS_RESERVED, 8'h00);
        $display("reset done");
        // Fill to trigger, drain in order.
        wr(OFS_CAUSE, 8'h01);
        wr(OFS_IRQMASK, 8'h01);
        i_urm_host_model.push(8'ha0);
        rdChk(OFS_LINESTAT, 8'h01);
        for (int i = 1; i < 7; i++) i_urm_host_model.push(8'ha0 + 8'(i));
        `CHK("irqN", 1'b1, irqN)
        rdChk(OFS_CAUSE, 8'hc1);
        i_urm_host_model.push(8'ha7);
        `CHK("irqN", 1'b0, irqN)
        rdChk(OFS_CAUSE, 8'hc4);
        rdChk(OFS_HOLD, 8'ha0);
        `CHK("irqN", 1'b1, irqN)
        rdChk(OFS_CAUSE, 8'hc1);
        for (int i = 1; i < 8; i++) rdChk(OFS_HOLD, 8'ha0 + 8'(i));
        rdChk(OFS_LINESTAT, 8'h00);
        $display("trigger done");
        // Receive outranks modem.
        modemChange = 1'b1;
        wr(OFS_IRQMASK, 8'h09);
        for (int i = 0; i < 8; i++) i_urm_host_model.push(8'(i));
        rdChk(OFS_CAUSE, 8'hc4);
        wr(OFS_CAUSE, 8'h03);
        rdChk(OFS_CAUSE, 8'hc0);
        `CHK("irqN", 1'b0, irqN)
        wr(OFS_IRQMASK, 8'h00);
        `CHK("irqN", 1'b1, irqN)
        modemChange = 1'b0;
        wr(OFS_HOLD, 8'h5a);
        `CHK("txChar", 8'h5a, txChar)
        $display("priority done");
        // Banks and shaded bits.
        wr(OFS_IRQMASK, 8'hf0);
        rdChk(OFS_IRQMASK, 8'h00);
        wr(OFS_FORMAT, 8'h80);
        wr(OFS_DIVLO, 8'h12);
        wr(OFS_DIVHI, 8'h34);
        wr(OFS_DIVFRAC, 8'h56);
        rdChk(OFS_DIVLO, 8'h12);
        rdChk(OFS_DIVHI, 8'h34);
        rdChk(OFS_DIVFRAC, 8'h00);
        wr(OFS_FORMAT, FORMAT_ENH_KEY);
        wr(OFS_ENHANCED, 8'h10);
        for (int i = 4; i < 8; i++) wr(4'(i), 8'hc0 + 8'(i));
        rdChk(OFS_RESUME2, 8'hc5);
        `CHK("flowChars", 32'hc4c5c6c7, flowChars)
        wr(OFS_FORMAT, 8'h80);
        wr(OFS_DIVFRAC, 8'h56);
        rdChk(OFS_DIVFRAC, 8'h56);
        rdChk(OFS_FORMAT, 8'h80);
        wr(OFS_FORMAT, 8'h03);
        wr(OFS_IRQMASK, 8'hf0);
        rdChk(OFS_IRQMASK, 8'hf0);
        $display("banks done");
        print_verdict();
    end
endmodule : urm_regs_tb
`default_nettype wire
